/* mptio_pkg.sv */
// mptio_pkg: constants shared by the multichannel pwm timer pin and buffer logic
package mptio_pkg;
  // data width of counter, general and buffer registers
  localparam int DW = 16;
  // number of buffered duty and carrier registers
  localparam int NBUF = 5;
  // buffer slots: ch3 duty b, ch4 duty a, ch4 duty b, carrier, ch4 general d
  localparam logic [2:0] BI_CH3_B = 3'h0;
  localparam logic [2:0] BI_CH4_A = 3'h1;
  localparam logic [2:0] BI_CH4_B = 3'h2;
  localparam logic [2:0] BI_CARRIER = 3'h3;
  localparam logic [2:0] BI_CH4_D = 3'h4;
  // operating mode codes of the four-bit mode field
  localparam logic [3:0] MD_NORMAL = 4'h0;
  localparam logic [3:0] MD_PWM1 = 4'h2;
  localparam logic [3:0] MD_PWM2 = 4'h3;
  localparam logic [3:0] MD_PHASE1 = 4'h4;
  localparam logic [3:0] MD_PHASE4 = 4'h7;
  localparam logic [3:0] MD_RSPWM = 4'h8;
  localparam logic [3:0] MD_CPWM_CREST = 4'hD;
  localparam logic [3:0] MD_CPWM_TROUGH = 4'hE;
  localparam logic [3:0] MD_CPWM_BOTH = 4'hF;
  // pin-control field bit positions and action codes
  localparam int PC_IN = 3;
  localparam int PC_LVL = 2;
  localparam logic [1:0] PC_HOLD = 2'h0;
  localparam logic [1:0] PC_CLR = 2'h1;
  localparam logic [1:0] PC_SET = 2'h2;
  localparam logic [1:0] PC_TGL = 2'h3;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_MODE3 = 8'h00;
  localparam logic [7:0] OFF_MODE4 = 8'h04;
  localparam logic [7:0] OFF_CH1_IOC = 8'h08;
  localparam logic [7:0] OFF_CH4_IOCH = 8'h0C;
  localparam logic [7:0] OFF_CH0_GC = 8'h10;
  localparam logic [7:0] OFF_CH1_GB = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1C;
  localparam logic [7:0] OFF_BUF0 = 8'h20;
  localparam logic [7:0] OFF_BUF4 = 8'h30;
  // reset values
  localparam logic [DW-1:0] CMP_RST = 16'hFFFF;
  localparam logic [DW-1:0] ZERO = 16'h0000;
  // counter direction
  typedef enum logic {DIR_UP, DIR_DOWN} mptio_dir_t;
endpackage : mptio_pkg

/* mptio_pin_ctl.sv */
// mptio_pin_ctl: compare-output and input-capture control for one timer pin
module mptio_pin_ctl
  import mptio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // control
  input wire logic [3:0] ctl,
  input wire logic ctl_load,
  input wire logic chain_en,
  // events
  input wire logic cmp_match,
  input wire logic chain_evt,
  // pin
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe,
  output logic cap_o
);
  logic prev_r; // last pin sample for edge detection
  logic rise;
  logic fall;
  logic cap_nxt;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  assign rise = pin_i & ~prev_r;
  assign fall = ~pin_i & prev_r;

  // output level: low from reset until a code with an initial level is loaded
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_o <= 1'b0; // RL11
    end else if (ctl[PC_IN]) begin
      pin_o <= pin_o; // capture mode: output level kept
    end else if (ctl_load && ctl[1:0] != PC_HOLD) begin
      pin_o <= ctl[PC_LVL]; // RL8
    end else if (cmp_match) begin
      case (ctl[1:0]) // RL8
        PC_CLR: pin_o <= 1'b0;
        PC_SET: pin_o <= 1'b1;
        PC_TGL: pin_o <= ~pin_o;
        default: pin_o <= pin_o;
      endcase
    end
  end

  // capture source: chained event, both edges, falling or rising
  always_comb begin
    if (!ctl[PC_IN]) begin
      cap_nxt = 1'b0;
    end else if (chain_en && ctl[PC_LVL]) begin
      cap_nxt = chain_evt; // RL10
    end else if (ctl[1]) begin
      cap_nxt = rise | fall; // RL9
    end else begin
      cap_nxt = ctl[0] ? fall : rise; // RL9
    end
  end

  // registered edge history, enable and capture strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      pin_oe <= 1'b0;
      cap_o <= 1'b0;
    end else begin
      prev_r <= pin_i;
      pin_oe <= ~ctl[PC_IN]; // RL8
      cap_o <= cap_nxt;
    end
  end

  init_level_a: assert property (ctl_load && !ctl[PC_IN] && ctl[1:0] != PC_HOLD
    |=> pin_o == $past(ctl[PC_LVL])) else $error("initial pin level wrong"); // RL8
  toggle_out_a: assert property (!ctl_load && !ctl[PC_IN] && ctl[1:0] == PC_TGL && cmp_match
    |=> pin_o != $past(pin_o)) else $error("toggle on match missing"); // RL8
  rise_cap_a: assert property (ctl == 4'h8 && rise |=> cap_o)
    else $error("rising edge not captured"); // RL9
endmodule : mptio_pin_ctl

/* mptio_buf_chain.sv */
// mptio_buf_chain: buffer, temporary and compare registers for the five duty and carrier slots
module mptio_buf_chain
  import mptio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // software write into a buffer
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire logic [DW-1:0] wr_dat,
  // timing
  input wire logic sub_busy,
  input wire logic upd,
  // state
  output logic [NBUF-1:0][DW-1:0] buf_o,
  output logic [NBUF-1:0][DW-1:0] cmp_o,
  output logic pend_o
);
  logic [NBUF-1:0][DW-1:0] tmp_r; // temporary stage
  logic xfer; // buffer to temporary move

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  assign xfer = pend_o & ~sub_busy; // RL14

  // buffers accept writes at any time
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_o <= {NBUF{CMP_RST}};
    end else if (wr_en) begin
      buf_o[wr_idx] <= wr_dat; // RL12
    end
  end

  // pending move: armed by the ch4 d write, held while the subcounter runs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_o <= 1'b0;
    end else begin
      pend_o <= (wr_en && wr_idx == BI_CH4_D) | (pend_o & sub_busy); // RL17 RL14
    end
  end

  // all five temporaries move together once the subcounter is stopped
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmp_r <= {NBUF{CMP_RST}};
    end else if (xfer) begin
      tmp_r <= buf_o; // RL13 RL17
    end
  end

  // compare registers load at the selected update point
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_o <= {NBUF{CMP_RST}};
    end else if (upd) begin
      cmp_o <= tmp_r; // RL15
    end
  end

  defer_busy_a: assert property (sub_busy |=> $stable(tmp_r))
    else $error("temporary moved while subcounter busy"); // RL14
  move_all_a: assert property (pend_o && !sub_busy |=> tmp_r == $past(buf_o))
    else $error("buffers not moved together"); // RL17
  d_arm_a: assert property (wr_en && wr_idx == BI_CH4_D ##1 !sub_busy
    |=> tmp_r[BI_CH4_D] == $past(wr_dat, 2)) else $error("d write did not move"); // RL13
  upd_load_a: assert property (upd |=> cmp_o == $past(tmp_r))
    else $error("compare not loaded at update point"); // RL15
  defer_cv: cover property (pend_o && sub_busy ##1 !sub_busy);
endmodule : mptio_buf_chain

/* mptio_top.sv */
// mptio_top: mode select, pin control and buffered pwm update for timer channels
//
// Overview of operation
// [RL1] mode field picks normal, pwm, phase, rspwm, cpwm
// [RL2] last cpwm code transfers at crest and trough
// [RL3] software keeps pwm mode 2 off channels 3,4
// [RL4] phase counting only on channels 1 and 2
// [RL5] rspwm and cpwm selected on channel 3 only
// [RL6] channel 4 follows channel 3 in those modes
// [RL7] software never puts channel 4 in those modes
// [RL8] output codes set initial level, match action
// [RL9] input codes capture on rise, fall or both
// [RL10] ch1 code 11xx captures on ch0 c event
// [RL11] pin low after reset until control written
// [RL12] five buffers writable at any time
// [RL13] buffer update rewrites temporary when subcounter stopped
// [RL14] no buffer move while subcounter counts
// [RL15] temporary to compare at mode update point
// [RL16] software writes ch4 d last
// [RL17] ch4 d write moves all five together
// [RL18] software rewrites ch4 d even if unchanged
// [RL19] reserved mode codes stop that channel only; a reserved channel 3 code here stops the shared counter for all channels
module mptio_top
  import mptio_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // dead-time subcounter state
  input wire logic dead_time_subcounter_busy,
  // channel 1 b pin
  input wire logic ch1_b_timer_pin_i,
  output logic ch1_b_timer_pin_o,
  output logic ch1_b_timer_pin_oe,
  // channel 4 a pin
  input wire logic ch4_a_timer_pin_i,
  output logic ch4_a_timer_pin_o,
  output logic ch4_a_timer_pin_oe,
  // update point strobe
  output logic update_pulse_o
);

  // byte-lane merge into a 16-bit register
  function automatic logic [DW-1:0] mptio_merge(
    input logic [DW-1:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [DW-1:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wd[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : mptio_merge

  // true for any defined operating mode code
  function automatic logic mptio_mode_ok(input logic [3:0] m);
    logic ok;
    ok = 1'b0;
    case (m) // RL1
      MD_NORMAL, MD_PWM1, MD_PWM2: ok = 1'b1;
      MD_RSPWM: ok = 1'b1;
      MD_CPWM_CREST, MD_CPWM_TROUGH, MD_CPWM_BOTH: ok = 1'b1;
      default: ok = (m >= MD_PHASE1 && m <= MD_PHASE4);
    endcase
    return ok;
  endfunction : mptio_mode_ok

  // true for the complementary pwm codes
  function automatic logic mptio_is_cpwm(input logic [3:0] m);
    return m == MD_CPWM_CREST || m == MD_CPWM_TROUGH || m == MD_CPWM_BOTH;
  endfunction : mptio_is_cpwm

  // software registers
  logic [3:0] mode3_r; // channel 3 mode field
  logic [3:0] mode4_r; // channel 4 mode field
  logic [7:0] ch1_pinctl_r; // ch1 pin control, b field high
  logic [7:0] ch4_pinctl_h_r; // ch4 pin control high, a field low
  logic [DW-1:0] ch0_gen_c_r; // ch0 general register c
  logic [DW-1:0] ch1_gen_b_r; // ch1 general register b
  // counter state
  logic [DW-1:0] cnt_r; // shared timer counter
  mptio_dir_t dir_r; // count direction
  // bus handshake
  logic req; // live bus request
  logic wr_hit; // write takes effect this edge
  logic ack_r;
  logic [31:0] rd_nxt;
  // pin control load strobes, one cycle after the write
  logic ch1_load_r;
  logic ch4_load_r;
  // derived modes
  logic run; // channel 3 mode defined
  logic cpwm; // complementary pwm active
  logic follow; // channel 4 slaved to channel 3
  logic [3:0] mode4_eff; // mode channel 4 really runs
  logic crest;
  logic trough;
  logic upd;
  // compare and capture events
  logic ch0c_evt;
  logic ch1b_match;
  logic ch4a_match;
  logic ch1_cap;
  logic ch4_cap;
  logic ch4_pin_sub;
  logic ch4_oe_sub;
  logic pwm4_r; // slaved pwm level for ch4
  logic ch1_written_r; // helper: ch1 control written since reset
  // buffer chain
  logic buf_wr;
  logic [2:0] buf_idx;
  logic [NBUF-1:0][DW-1:0] buf_v;
  logic [NBUF-1:0][DW-1:0] cmp_v;
  logic pend;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // bus decode: one-wait-state slave, write lands at the ack edge
  assign req = wb_cyc_i & wb_stb_i;
  assign wr_hit = req & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;
  assign buf_idx = 3'(wb_adr_i[4:2]);
  assign buf_wr = wr_hit && wb_adr_i >= OFF_BUF0 && wb_adr_i <= OFF_BUF4;

  // ack pulses one cycle, then drops even if the master lingers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    case (wb_adr_i)
      OFF_MODE3: rd_nxt[3:0] = mode3_r;
      OFF_MODE4: rd_nxt[3:0] = mode4_r;
      OFF_CH1_IOC: rd_nxt[7:0] = ch1_pinctl_r;
      OFF_CH4_IOCH: rd_nxt[7:0] = ch4_pinctl_h_r;
      OFF_CH0_GC: rd_nxt[DW-1:0] = ch0_gen_c_r;
      OFF_CH1_GB: rd_nxt[DW-1:0] = ch1_gen_b_r;
      OFF_COUNT: rd_nxt[DW-1:0] = cnt_r;
      OFF_STATUS: rd_nxt[4:0] = {dir_r == DIR_DOWN, pend, follow,
                                 ch1_b_timer_pin_o, ch4_a_timer_pin_o};
      default: begin
        if (wb_adr_i >= OFF_BUF0 && wb_adr_i <= OFF_BUF4) begin
          rd_nxt[DW-1:0] = buf_v[buf_idx];
        end
      end
    endcase
  end

  // read data captured with the ack so it comes from a flip-flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !ack_r) begin
      wb_dat_o <= rd_nxt;
    end
  end

  // mode fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode3_r <= MD_NORMAL;
      mode4_r <= MD_NORMAL;
    end else if (wr_hit && wb_sel_i[0]) begin
      if (wb_adr_i == OFF_MODE3) begin
        mode3_r <= wb_dat_i[3:0];
      end
      if (wb_adr_i == OFF_MODE4) begin
        mode4_r <= wb_dat_i[3:0];
      end
    end
  end

  // pin control registers; reset code holds the low level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch1_pinctl_r <= 8'h00;
      ch4_pinctl_h_r <= 8'h00;
      ch1_load_r <= 1'b0;
      ch4_load_r <= 1'b0;
    end else begin
      ch1_load_r <= wr_hit && wb_sel_i[0] && wb_adr_i == OFF_CH1_IOC;
      ch4_load_r <= wr_hit && wb_sel_i[0] && wb_adr_i == OFF_CH4_IOCH;
      if (wr_hit && wb_sel_i[0] && wb_adr_i == OFF_CH1_IOC) begin
        ch1_pinctl_r <= wb_dat_i[7:0];
      end
      if (wr_hit && wb_sel_i[0] && wb_adr_i == OFF_CH4_IOCH) begin
        ch4_pinctl_h_r <= wb_dat_i[7:0];
      end
    end
  end

  // helper flag: pin has seen a control write since reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch1_written_r <= 1'b0;
    end else if (ch1_load_r) begin
      ch1_written_r <= 1'b1;
    end
  end

  // ch0 general register c, compare source for the ch1 chain
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch0_gen_c_r <= CMP_RST;
    end else if (wr_hit && wb_adr_i == OFF_CH0_GC) begin
      ch0_gen_c_r <= mptio_merge(ch0_gen_c_r, wb_dat_i, wb_sel_i);
    end
  end

  // ch1 general register b: a capture beats a same-cycle bus write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ch1_gen_b_r <= CMP_RST;
    end else if (ch1_cap) begin
      ch1_gen_b_r <= cnt_r; // RL9 RL10
    end else if (wr_hit && wb_adr_i == OFF_CH1_GB) begin
      ch1_gen_b_r <= mptio_merge(ch1_gen_b_r, wb_dat_i, wb_sel_i);
    end
  end

  // mode decode; a reserved channel 3 code stops the shared counter and the run-gated events
  assign run = mptio_mode_ok(mode3_r); // RL19
  assign cpwm = mptio_is_cpwm(mode3_r); // RL1
  assign follow = cpwm || mode3_r == MD_RSPWM; // RL6
  assign mode4_eff = follow ? mode3_r : mode4_r; // RL6
  assign crest = run && dir_r == DIR_UP && cnt_r == cmp_v[BI_CARRIER];
  assign trough = run && dir_r == DIR_DOWN && cnt_r == ZERO;

  // update point by mode: crest, trough or both; others at wrap
  always_comb begin
    case (mode3_r) // RL15
      MD_CPWM_CREST: upd = crest;
      MD_CPWM_TROUGH: upd = trough;
      MD_CPWM_BOTH: upd = crest | trough; // RL2
      default: upd = crest;
    endcase
  end
  assign update_pulse_o = upd;

  // counter: up/down in complementary pwm, else up with wrap at carrier
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= ZERO;
      dir_r <= DIR_UP;
    end else if (!run) begin
      cnt_r <= cnt_r; // RL19
    end else if (crest) begin
      dir_r <= cpwm ? DIR_DOWN : DIR_UP;
      cnt_r <= cpwm ? DW'(cnt_r - 1'b1) : ZERO;
    end else if (trough) begin
      dir_r <= DIR_UP;
      cnt_r <= DW'(cnt_r + 1'b1);
    end else if (dir_r == DIR_DOWN) begin
      cnt_r <= DW'(cnt_r - 1'b1);
    end else begin
      cnt_r <= DW'(cnt_r + 1'b1);
    end
  end

  // compare events; a reserved channel 4 mode raises none
  assign ch0c_evt = run && cnt_r == ch0_gen_c_r;
  assign ch1b_match = run && cnt_r == ch1_gen_b_r;
  assign ch4a_match = mptio_mode_ok(mode4_eff) && cnt_r == cmp_v[BI_CH4_A]; // RL19

  // slaved pwm level: high while count is below duty a
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwm4_r <= 1'b0;
    end else begin
      pwm4_r <= cnt_r < cmp_v[BI_CH4_A];
    end
  end

  // channel 4 pin ignores its own control while slaved
  assign ch4_a_timer_pin_o = follow ? pwm4_r : ch4_pin_sub; // RL6
  assign ch4_a_timer_pin_oe = follow | ch4_oe_sub; // RL6

  // channel 1 b pin
  mptio_pin_ctl u_ch1b (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl(ch1_pinctl_r[7:4]),
    .ctl_load(ch1_load_r),
    .chain_en(1'b1),
    .cmp_match(ch1b_match),
    .chain_evt(ch0c_evt),
    .pin_i(ch1_b_timer_pin_i),
    .pin_o(ch1_b_timer_pin_o),
    .pin_oe(ch1_b_timer_pin_oe),
    .cap_o(ch1_cap)
  );

  // channel 4 a pin, no chained capture source
  mptio_pin_ctl u_ch4a (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .ctl(ch4_pinctl_h_r[3:0]),
    .ctl_load(ch4_load_r),
    .chain_en(1'b0),
    .cmp_match(ch4a_match),
    .chain_evt(1'b0),
    .pin_i(ch4_a_timer_pin_i),
    .pin_o(ch4_pin_sub),
    .pin_oe(ch4_oe_sub),
    .cap_o(ch4_cap)
  );

  // buffered duty and carrier registers
  mptio_buf_chain u_bufs (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .wr_en(buf_wr),
    .wr_idx(buf_idx),
    .wr_dat(mptio_merge(buf_v[buf_idx], wb_dat_i, wb_sel_i)),
    .sub_busy(dead_time_subcounter_busy),
    .upd(upd),
    .buf_o(buf_v),
    .cmp_o(cmp_v),
    .pend_o(pend)
  );

  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_resp_a: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  pin_low_a: assert property (!ch1_written_r |-> !ch1_b_timer_pin_o)
    else $error("pin left low level before control write"); // RL11
  cap_count_a: assert property (ch1_cap |=> ch1_gen_b_r == $past(cnt_r))
    else $error("capture did not store the count"); // RL9
  chain_cap_a: assert property (ch1_pinctl_r[7:6] == 2'h3 && ch0c_evt && !ch1_load_r
    |=> ##1 ch1_gen_b_r == $past(cnt_r)) else $error("chained capture missing"); // RL10
  follow_pin_a: assert property (follow && $past(follow)
    |-> ch4_a_timer_pin_o == ($past(cnt_r) < $past(cmp_v[BI_CH4_A])))
    else $error("channel 4 not following channel 3"); // RL6
  both_upd_a: assert property (mode3_r == MD_CPWM_BOTH && (crest || trough)
    |-> upd) else $error("update missed"); // RL2
  trough_only_a: assert property (mode3_r == MD_CPWM_TROUGH && crest |-> !upd)
    else $error("crest update in trough mode"); // RL15
  cpwm_turn_a: assert property (cpwm && crest |=> dir_r == DIR_DOWN)
    else $error("counter did not turn at crest"); // RL1
  reserved_a: assert property (!run |=> $stable(cnt_r))
    else $error("counter ran in a reserved mode"); // RL19

  both_cv: cover property (mode3_r == MD_CPWM_BOTH && trough);
  cap_cv: cover property (ch1_cap);
  follow_cv: cover property (follow && ch4a_match);
endmodule : mptio_top

/* mptio_pin_model.sv */
// mptio_pin_model: external circuit on one timer pin, with pull-down
module mptio_pin_model (
  // design side of the pin
  input wire logic pin_o,
  input wire logic pin_oe,
  // stimulus from the bench
  input wire logic drv_en,
  input wire logic drv_lvl,
  // resolved level back into the design
  output logic pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // design wins while it drives; the far end only drives a released pin,
  // otherwise the pull-down holds the line low rather than the last value
  always_comb begin
    if (pin_oe) begin
      pin_i = pin_o;
    end else if (drv_en) begin
      pin_i = drv_lvl;
    end else begin
      pin_i = 1'b0;
    end
  end
endmodule : mptio_pin_model

/* mptio_bench.sv */
// mptio_bench: register-driven tests of pin control, buffers and update points
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
  $display("mismatch %s exp %0h seen %0h", nm, e, s); end end
module mptio_bench;
  import mptio_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and bus
  logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  // subcounter, pins and update strobe
  logic busy, p1_i, p1_o, p1_oe, p4_i, p4_o, p4_oe, update_pulse_o;
  logic d1_en, d1_lvl, d4_en, d4_lvl; // far-end drive commands
  int n_errors, checks_done, gn, gc, gt, gb;
  logic [31:0] q, r; // last read data
  logic [15:0] gcv; // chained compare value
  // last code leaves the pin low, so releasing it to the pull-down makes no edge
  logic [3:0] codes [8] = '{4'h1, 4'h0, 4'h5, 4'h4, 4'h2, 4'h6, 4'h7, 4'h3};
  logic lv [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [3:0] md [3] = '{MD_NORMAL, MD_PWM1, MD_RSPWM};
  mptio_top mptio_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .dead_time_subcounter_busy(busy), .ch1_b_timer_pin_i(p1_i), .ch1_b_timer_pin_o(p1_o),
    .ch1_b_timer_pin_oe(p1_oe), .ch4_a_timer_pin_i(p4_i), .ch4_a_timer_pin_o(p4_o),
    .ch4_a_timer_pin_oe(p4_oe), .update_pulse_o(update_pulse_o));
  mptio_pin_model mptio_pin_model_i (.pin_o(p1_o), .pin_oe(p1_oe), .drv_en(d1_en),
    .drv_lvl(d1_lvl), .pin_i(p1_i));
  mptio_pin_model mptio_pin_model_a_i (.pin_o(p4_o), .pin_oe(p4_oe), .drv_en(d4_en),
    .drv_lvl(d4_lvl), .pin_i(p4_i));
  // free-running 25 mhz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // verdict and end of run, also reached from any timeout
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // one classic cycle; request held until ack is sampled, then released
  task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin n_errors++; results(); end
  endtask : xfer
  // bounded wait for the update strobe, g counts the cycles waited
  task automatic wait_upd(input int lim, output int g);
    g = 0;
    do begin @(posedge sys_clk); g++; end while (update_pulse_o !== 1'b1 && g < lim);
    if (update_pulse_o !== 1'b1) begin n_errors++; results(); end
  endtask : wait_upd
  // spacing between two consecutive update points
  task automatic gap(output int g);
    int n;
    wait_upd(300, n);
    wait_upd(300, g);
  endtask : gap
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, busy, d1_en, d1_lvl, d4_en, d4_lvl} = 8'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    n_errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("ch1 pin after reset", 1'b0, p1_o);
    xfer(OFF_CH0_GC, 1'b0, 32'h0); `CHK("ch0 c reset", 32'h0000_FFFF, q);
    xfer(8'h40, 1'b0, 32'h0); `CHK("unmapped read", 32'h0000_0000, q);
    // initial level per output code; hold codes keep the previous level
    for (int i = 0; i < 8; i++) begin
      xfer(OFF_CH1_IOC, 1'b1, {24'h0, codes[i], 4'h0});
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK("ch1 pin level", lv[i], p1_o);
      `CHK("ch1 pin drive", 1'b1, p1_oe);
    end
    $display("test output codes done");
    // falling-edge capture: a rise must not capture, a fall must
    xfer(OFF_CH1_IOC, 1'b1, 32'h90);
    d1_en <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK("ch1 released", 1'b0, p1_oe);
    d1_lvl <= 1'b1;
    repeat (4) @(posedge sys_clk);
    xfer(OFF_CH1_GB, 1'b0, 32'h0); `CHK("no capture on rise", 32'h0000_FFFF, q);
    d1_lvl <= 1'b0;
    repeat (4) @(posedge sys_clk);
    xfer(OFF_CH1_GB, 1'b0, 32'h0); `CHK("capture on fall", 1'b1, q[15:0] !== 16'hFFFF);
    // chained capture on the channel 0 c compare match
    xfer(OFF_COUNT, 1'b0, 32'h0);
    gcv = q[15:0] + 16'h0040;
    xfer(OFF_CH0_GC, 1'b1, {16'h0, gcv});
    xfer(OFF_CH1_GB, 1'b1, 32'h0000_FFFF);
    xfer(OFF_CH1_IOC, 1'b1, 32'hC0);
    repeat (100) @(posedge sys_clk);
    xfer(OFF_CH1_GB, 1'b0, 32'h0); `CHK("chained capture", 1'b1, (q[15:0] - gcv) < 16'h3);
    $display("test capture done");
    // buffer moves while the subcounter counts are deferred
    busy <= 1'b1;
    xfer(OFF_BUF0, 1'b1, 32'h1234);
    xfer(OFF_BUF0 + 8'h0C, 1'b1, 32'h0010);
    xfer(OFF_STATUS, 1'b0, 32'h0); `CHK("no pend before d", 1'b0, q[3]);
    xfer(OFF_BUF4, 1'b1, 32'hFFFF);
    repeat (3) @(posedge sys_clk);
    xfer(OFF_STATUS, 1'b0, 32'h0); `CHK("pend while busy", 1'b1, q[3]);
    busy <= 1'b0;
    repeat (3) @(posedge sys_clk);
    xfer(OFF_STATUS, 1'b0, 32'h0); `CHK("moved after halt", 1'b0, q[3]);
    xfer(OFF_BUF0, 1'b0, 32'h0); `CHK("buffer readback", 32'h0000_1234, q);
    xfer(OFF_BUF4, 1'b1, 32'hFFFF);
    repeat (3) @(posedge sys_clk);
    xfer(OFF_STATUS, 1'b0, 32'h0); `CHK("idle move done", 1'b0, q[3]);
    $display("test buffers done");
    // carrier takes effect at the first wrap of the full-range count
    wait_upd(70000, gn);
    xfer(OFF_CH4_IOCH, 1'b1, 32'h08);
    repeat (2) @(posedge sys_clk);
    #1;
    `CHK("ch4 input mode", 1'b0, p4_oe);
    // far end raises the released ch4 pin: a rising-edge capture
    d4_en <= 1'b1;
    d4_lvl <= 1'b1;
    repeat (3) @(posedge sys_clk);
    xfer(OFF_MODE4, 1'b1, {28'h0, MD_PWM1});
    for (int i = 0; i < 3; i++) begin
      xfer(OFF_MODE3, 1'b1, {28'h0, md[i]});
      gap(gn);
      `CHK("wrap update gap", 17, gn);
    end
    // carrier 16: up and down round trip is 32 cycles, crest to trough 16
    xfer(OFF_MODE3, 1'b1, {28'h0, MD_CPWM_CREST}); gap(gc);
    `CHK("crest gap", 32, gc);
    xfer(OFF_MODE3, 1'b1, {28'h0, MD_CPWM_TROUGH}); gap(gt);
    `CHK("trough gap", 32, gt);
    xfer(OFF_MODE3, 1'b1, {28'h0, MD_CPWM_BOTH}); gap(gb);
    `CHK("crest and trough gap", 16, gb);
    xfer(OFF_CH4_IOCH, 1'b1, 32'h08);
    repeat (3) @(posedge sys_clk);
    #1;
    `CHK("ch4 follows ch3", 1'b1, p4_oe);
    $display("test update points done");
    // reserved code stops the shared counter
    xfer(OFF_MODE3, 1'b1, 32'h1);
    xfer(OFF_COUNT, 1'b0, 32'h0);
    r = q;
    repeat (10) @(posedge sys_clk);
    xfer(OFF_COUNT, 1'b0, 32'h0); `CHK("count frozen", r, q);
    $display("test reserved mode done");
    results();
  end
endmodule : mptio_bench
